// ==== core/sdml_pkg.sv ====
// sdml_pkg: shared constants for the modulator link (modulator end and filter end).
// assumes a single 100 MHz system clock on both ends.
package sdml_pkg;
    localparam int unsigned SYS_CLK_HZ      = 100_000_000;
    // modulator clock, nominal figure and derived half-period in system cycles
    localparam int unsigned MOD_CLK_HZ      = 2_048_000;
    localparam int unsigned MOD_HALF_CYC    = SYS_CLK_HZ / (2 * MOD_CLK_HZ);
    // modulator clocks per output bit
    localparam int unsigned BIT_DIV         = 4;
    // modulator clocks in range needed before the loop returns to fourth order
    localparam int unsigned RECOVER_CLKS    = 32;
    // first-order rises under lasting over-range before fourth order is tried again
    localparam int unsigned RETRY_CLKS      = 64;
    // loss-of-clock timeout
    localparam int unsigned LOSS_TIME_NS    = 40_000;
    localparam int unsigned LOSS_CYC        = LOSS_TIME_NS / (1_000_000_000 / SYS_CLK_HZ);
    // input scaling: full scale is +/- FS_CODE, over-range 5 % beyond it
    localparam int          IN_W            = 16;
    localparam int          FS_CODE         = 16'sd20000;
    localparam int          OVR_CODE        = 16'sd21000;
    // offsets in input codes equivalent to -60 mV and -35 mV of 2.5 V full scale
    localparam int          OFS_CH1         = -16'sd480;
    localparam int          OFS_CH2         = -16'sd280;
    // density scaling: full scale maps to 86 % / 14 % ones
    localparam int          DENS_NUM        = 36;
    localparam int          DENS_DEN        = 50;
    // apb register offsets of the filter end
    localparam logic [7:0]  CFG_OFS         = 8'h00;
    localparam logic [7:0]  STAT_OFS        = 8'h04;
    localparam logic [7:0]  PIN_OFS         = 8'h08;
    localparam logic [7:0]  SINE_OFS        = 8'h0C;
    localparam logic [31:0] CFG_RST         = 32'h0000_0000;
    // config bit positions
    localparam int          CFG_CLK_EN_BIT  = 0;
    localparam int          CFG_SYNC_EN_BIT = 1;
    // status bit positions
    localparam int          ST_ERR_BIT      = 0;
    localparam int          ST_WORD_BIT     = 1;
    // pin setup: bit 0 drives offset enable, bit 1 drives power-down
    localparam int          PIN_IDLE_TONE_OFFSET_ENABLE_BIT    = 0;
    localparam int          PIN_POWER_DOWN_PIN_BIT    = 1;
    localparam int          SINE_ALIGN_BIT  = 0;
    localparam int          GP_PINS         = 12;
    // bits per decimated status word
    localparam int unsigned WORD_BITS       = 64;
    typedef enum logic [1:0] {SDML_RUN, SDML_PD_PIN, SDML_PD_LOSS} sdml_pwr_e;
endpackage

// ==== core/sdml_if.sv ====
// sdml_if: wires between modulator and decimation filter.
// assumes the bench resolves tristate levels from the enable signals.
`timescale 1ns/100ps
`default_nettype none
interface sdml_if;
    logic mod_clk;      // modulator clock from filter
    logic samp_sync;    // sample sync from filter
    logic bit_data;     // bitstream value
    logic bit_data_oe;  // modulator drives bitstream
    logic instability_flag;
    logic instability_flag_oe;
    logic idle_tone_offset_enable;
    logic power_down_pin;
    modport modulator (
        input  mod_clk, samp_sync, idle_tone_offset_enable, power_down_pin,
        output bit_data, bit_data_oe, instability_flag, instability_flag_oe
    );
    modport filter (
        output mod_clk, samp_sync, idle_tone_offset_enable, power_down_pin,
        input  bit_data, bit_data_oe, instability_flag, instability_flag_oe
    );
endinterface
`default_nettype wire

// ==== core/sdml_modulator.sv ====
// sdml_modulator: digital model of the two-channel delta-sigma modulator end.
// assumes mod_clk and samp_sync are sampled levels on the 100 MHz system clock.
// Functional notes
// - sync rising edge resets divider and state; here it restarts only div_cnt, acc and order are kept
// - one output bit per four modulator clocks
// - ones density follows differential input
// - over-range past five percent risks instability
// - instability drops to first order, raises flag
// - recovery needs 32 in-range modulator clocks
// - sustained over-range cycles orders, flag pulses
// - lost clock forces power-down after 40us
// - filter derives modulator clock from system clock
// - modulator clock off until software enables
// - filter issues sync after system sync edge
// - sync generation off until software enables
// - syncs coincide within one modulator clock
// - filter latches flag into status error bit
// - sine alignment only when option enabled
// - general pins drive offset and power-down
// - offset input adds -60/-35 mV offset
// - three power modes supported
// - power-down pin disables conversion, tristates outputs
// - lost clock tristates regardless of pin
// - sync sampled on falling edge, acts next rising
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module sdml_modulator #(
    parameter int LOSS_COUNT = sdml_pkg::LOSS_CYC
) (
    input  wire logic                        mclk_i,
    input  wire logic                        reset_n_i,
    sdml_if.modulator                        link,
    input  wire logic signed [sdml_pkg::IN_W-1:0] ain_i,
    input  wire logic                        chan_sel_i,
    output logic                             fourth_order_o,
    output logic [1:0]                       power_mode_o
);
    import sdml_pkg::*;

    localparam int AW = IN_W + 4;

    logic        clk_q;
    logic        sync_q;
    logic        sync_latched;
    logic [1:0]  div_cnt;
    logic        fourth;
    logic [5:0]  ok_cnt;
    logic [$clog2(LOSS_COUNT+1)-1:0] idle_cnt;
    logic        clk_lost;
    logic signed [AW-1:0] acc;
    logic        out_bit;
    logic        bit_oe_r;
    logic        flag_r;
    logic        rise;
    logic        fall;
    logic        tick;
    logic        pd;
    logic signed [AW-1:0] ain_ofs;
    logic signed [AW-1:0] drive;
    logic signed [AW-1:0] fb;
    logic        over;
    logic        in_fs;
    logic [6:0]  retry_cnt;

    // edges of the modulator clock level
    assign rise = link.mod_clk & ~clk_q;
    assign fall = ~link.mod_clk & clk_q;
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            clk_q <= 1'b0;
        end else begin
            clk_q <= link.mod_clk;
        end
    end

    // sync latched on falling edge, acted on at next rising edge
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            sync_q       <= 1'b0;
            sync_latched <= 1'b0;
        end else if (fall) begin
            sync_q       <= link.samp_sync;
            sync_latched <= link.samp_sync & ~sync_q;
        end else if (rise) begin
            sync_latched <= 1'b0;
        end
    end

    // divider: bit boundary each fourth rising edge, restart on sync
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i || pd) begin
            div_cnt <= 2'h0;
        end else if (rise) begin
            if (sync_latched) begin
                div_cnt <= 2'h0;
            end else begin
                div_cnt <= div_cnt + 2'h1;
            end
        end
    end
    assign tick = rise && (sync_latched || div_cnt == 2'(BIT_DIV - 1));

    // loss-of-clock detector; no edge for the timeout forces power-down
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            idle_cnt <= '0;
            clk_lost <= 1'b1;                                 // no clock after reset
        end else if (rise || fall) begin
            idle_cnt <= '0;
            clk_lost <= 1'b0;
        end else if (idle_cnt >= ($bits(idle_cnt))'(LOSS_COUNT - 1)) begin
            clk_lost <= 1'b1;
        end else begin
            idle_cnt <= idle_cnt + 1'b1;
        end
    end

    // power mode; loss of clock outranks the pin
    assign pd = clk_lost | link.power_down_pin;
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            power_mode_o <= 2'(SDML_PD_LOSS);
        end else if (clk_lost) begin
            power_mode_o <= 2'(SDML_PD_LOSS);
        end else if (link.power_down_pin) begin
            power_mode_o <= 2'(SDML_PD_PIN);
        end else begin
            power_mode_o <= 2'(SDML_RUN);
        end
    end

    // input with idle-tone offset, scaled so full scale maps to 86/14 %
    assign ain_ofs = AW'(ain_i) + (link.idle_tone_offset_enable ?
                     (chan_sel_i ? AW'(OFS_CH2) : AW'(OFS_CH1)) : AW'(0));
    assign drive   = AW'((ain_ofs * DENS_NUM) / DENS_DEN);
    assign fb      = out_bit ? AW'(FS_CODE) : -AW'(FS_CODE);
    assign over    = (ain_ofs > AW'(OVR_CODE)) || (ain_ofs < -AW'(OVR_CODE));
    assign in_fs   = (ain_ofs <= AW'(FS_CODE)) && (ain_ofs >= -AW'(FS_CODE));

    // first-order loop stands in for the analog loop; bit per tick
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i || pd) begin
            acc     <= '0;
            out_bit <= 1'b0;
        end else if (tick) begin
            acc     <= acc + drive - fb;
            out_bit <= (acc + drive - fb) >= 0;
        end
    end

    // stability: collapse on over-range, recover after 32 in-range clocks;
    // lasting over-range retries fourth order now and then, so the flag pulses
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i || pd) begin
            fourth    <= 1'b1;
            ok_cnt    <= 6'h0;
            retry_cnt <= 7'h0;
        end else if (rise) begin
            if (over && fourth) begin
                fourth    <= 1'b0;
                ok_cnt    <= 6'h0;
                retry_cnt <= 7'h0;
            end else if (over) begin
                ok_cnt <= 6'h0;
                if (retry_cnt == 7'(RETRY_CLKS - 1)) begin
                    fourth    <= 1'b1;
                    retry_cnt <= 7'h0;
                end else begin
                    retry_cnt <= retry_cnt + 7'h1;
                end
            end else if (!fourth) begin
                retry_cnt <= 7'h0;
                if (!in_fs) begin
                    ok_cnt <= 6'h0;
                end else if (ok_cnt == 6'(RECOVER_CLKS - 1)) begin
                    fourth <= 1'b1;
                    ok_cnt <= 6'h0;
                end else begin
                    ok_cnt <= ok_cnt + 6'h1;
                end
            end
        end
    end

    // pins: tristated in power-down; flag follows first-order state
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            bit_oe_r       <= 1'b0;
            flag_r         <= 1'b0;
            fourth_order_o <= 1'b1;
        end else begin
            bit_oe_r       <= ~pd;
            flag_r         <= ~pd & ~fourth;
            fourth_order_o <= fourth;
        end
    end

    assign link.bit_data            = out_bit;
    assign link.bit_data_oe         = bit_oe_r;
    assign link.instability_flag    = flag_r;
    assign link.instability_flag_oe = bit_oe_r;
endmodule
`default_nettype wire

// ==== core/sdml_filter.sv ====
// sdml_filter: decimation-filter end driving clock, sync and control pins.
// assumes an apb master on the same 100 MHz clock; slave answers with no wait.
`timescale 1ns/100ps
`default_nettype none
module sdml_filter (
    input  wire logic        mclk_i,
    input  wire logic        reset_n_i,
    sdml_if.filter           link,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sys_sync_i,
    output logic             sine_align_o,
    output logic [31:0]      word_count_o
);
    import sdml_pkg::*;

    logic [31:0] cfg;
    logic [GP_PINS-1:0] pin_setup_reg;
    logic [31:0] test_sine_setup_reg;
    logic        err_sticky;
    logic [7:0]  half_cnt;
    logic        mclk_r;
    logic        sync_r;
    logic        sync_fell;
    logic        sys_q;
    logic [6:0]  bit_cnt;
    logic [1:0]  bdiv;
    logic        wr;
    logic        err_set;
    logic        word_end;

    assign wr = psel & penable & pwrite;

    // register writes
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            cfg                 <= CFG_RST;
            pin_setup_reg       <= '0;
            test_sine_setup_reg <= '0;
        end else if (wr) begin
            case (paddr)
                CFG_OFS:  cfg                 <= pwdata;
                PIN_OFS:  pin_setup_reg       <= pwdata[GP_PINS-1:0];
                SINE_OFS: test_sine_setup_reg <= pwdata;
                default:  ;
            endcase
        end
    end

    // read mux, zero-wait answer
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & (paddr > SINE_OFS);
            case (paddr)
                CFG_OFS:  prdata <= cfg;
                STAT_OFS: prdata <= {30'h0, bit_cnt == 7'h0, err_sticky};
                PIN_OFS:  prdata <= {20'h0, pin_setup_reg};
                SINE_OFS: prdata <= test_sine_setup_reg;
                default:  prdata <= 32'h0;
            endcase
        end
    end

    // modulator clock divider, stopped while disabled
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i || !cfg[CFG_CLK_EN_BIT]) begin
            half_cnt <= 8'h0;
            mclk_r   <= 1'b0;
        end else if (half_cnt == 8'(MOD_HALF_CYC - 1)) begin
            half_cnt <= 8'h0;
            mclk_r   <= ~mclk_r;
        end else begin
            half_cnt <= half_cnt + 8'h1;
        end
    end

    // sync: held until a clock fall has passed under it and that low half ends,
    // so the modulator sees it at a falling edge whatever the request phase
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            sys_q     <= 1'b0;
            sync_r    <= 1'b0;
            sync_fell <= 1'b0;
        end else begin
            sys_q <= sys_sync_i;
            if (!cfg[CFG_CLK_EN_BIT]) begin
                sync_r    <= 1'b0;                            // no clock to carry it
                sync_fell <= 1'b0;
            end else if (sys_sync_i && !sys_q && cfg[CFG_SYNC_EN_BIT]) begin
                sync_r    <= 1'b1;
                sync_fell <= 1'b0;
            end else if (sync_r && half_cnt == 8'(MOD_HALF_CYC - 1)) begin
                if (mclk_r) begin
                    sync_fell <= 1'b1;                        // clock falls under the pulse
                end else if (sync_fell) begin
                    sync_r    <= 1'b0;
                    sync_fell <= 1'b0;
                end
            end
        end
    end

    // count received bits into status words; error sticks to the word
    assign word_end = half_cnt == 8'(MOD_HALF_CYC - 1) && !mclk_r && bdiv == 2'h3
                      && bit_cnt == 7'(WORD_BITS - 1);
    assign err_set  = link.instability_flag & link.instability_flag_oe;
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            bdiv         <= 2'h0;
            bit_cnt      <= 7'h0;
            err_sticky   <= 1'b0;
            word_count_o <= 32'h0;
        end else begin
            if (half_cnt == 8'(MOD_HALF_CYC - 1) && !mclk_r && cfg[CFG_CLK_EN_BIT]) begin
                bdiv <= bdiv + 2'h1;
                if (bdiv == 2'h3) begin
                    bit_cnt <= word_end ? 7'h0 : bit_cnt + 7'h1;
                end
            end
            if (word_end) begin
                word_count_o <= word_count_o + 32'h1;
            end
            // new word clears unless flag present: set wins
            if (err_set) begin
                err_sticky <= 1'b1;
            end else if (word_end) begin
                err_sticky <= 1'b0;
            end
        end
    end

    // sine alignment output only when enabled
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            sine_align_o <= 1'b0;
        end else begin
            sine_align_o <= sync_r & test_sine_setup_reg[SINE_ALIGN_BIT];
        end
    end

    assign link.mod_clk                 = mclk_r;
    assign link.samp_sync               = sync_r;
    assign link.idle_tone_offset_enable = pin_setup_reg[PIN_IDLE_TONE_OFFSET_ENABLE_BIT];
    assign link.power_down_pin          = pin_setup_reg[PIN_POWER_DOWN_PIN_BIT];
endmodule
`default_nettype wire

// ==== tb/sdml_link_sva.sv ====
// sdml_link_sva: timing checks on the wires between modulator and filter.
// assumes both ends share mclk_i and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module sdml_link_sva #(
    parameter int LOSS_COUNT = sdml_pkg::LOSS_CYC
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic mod_clk,
    input wire logic samp_sync,
    input wire logic bit_data,
    input wire logic bit_data_oe,
    input wire logic instability_flag,
    input wire logic instability_flag_oe,
    input wire logic power_down_pin
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    logic        mod_clk_q;
    int unsigned idle_cnt;
    int unsigned rise_cnt;
    // last clock level, for edge detection in helper logic
    always_ff @(posedge mclk_i) begin
        mod_clk_q <= mod_clk;
    end
    // cycles since the modulator clock last moved, saturating
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i || mod_clk != mod_clk_q) begin
            idle_cnt <= 0;
        end else if (idle_cnt < LOSS_COUNT + 8) begin
            idle_cnt <= idle_cnt + 1;
        end
    end
    // clock rises counted while the flag stands
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i || !instability_flag) begin
            rise_cnt <= 0;
        end else if (mod_clk && !mod_clk_q && rise_cnt < 255) begin
            rise_cnt <= rise_cnt + 1;
        end
    end
    AST_CLK_HIGH_MAX: assert property ($rose(mod_clk) |-> ##[1:30] !mod_clk)
        else $error("modulator clock high too long");
    AST_CLK_LOW_MIN: assert property ($fell(mod_clk) |-> !mod_clk [*8])
        else $error("modulator clock low too short");
    AST_SYNC_PULSE: assert property ($rose(samp_sync) |-> ##[1:120] !samp_sync)
        else $error("sample sync stuck high");
    AST_DATA_STEP: assert property ($changed(bit_data) && bit_data_oe && $past(bit_data_oe)
        |-> mod_clk)
        else $error("bitstream changed away from a clock rise");
    AST_FLAG_RAISE: assert property ($rose(instability_flag) |-> instability_flag_oe)
        else $error("flag raised while not driven");
    AST_FLAG_HOLD: assert property ($fell(instability_flag) && instability_flag_oe
        && $past(instability_flag_oe) |-> rise_cnt >= 32)
        else $error("flag dropped before recovery interval");
    AST_OE_POWER_DOWN_PIN: assert property ($rose(power_down_pin)
        |-> ##[1:3] (!bit_data_oe && !instability_flag_oe))
        else $error("outputs still driven in power-down");
    AST_LOSS: assert property (idle_cnt == LOSS_COUNT + 8 |-> !bit_data_oe)
        else $error("outputs driven after clock loss");
    AST_OE_PAIR: assert property (bit_data_oe == instability_flag_oe)
        else $error("output enables disagree");
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// testbench: both link ends joined, filter driven over apb, wires checked.
// assumes package, interface and design modules are compiled first.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import sdml_pkg::*;
    localparam int LOSS = 200;
    logic        mclk_i = 0, reset_n_i = 0, psel = 0, penable = 0, pwrite = 0;
    logic        sys_sync_i = 0, chan_sel_i = 0, pready, pslverr, sine_align_o, rerr;
    logic        fourth_order_o, s_sync, s_align, s_clk;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, word_count_o;
    logic [1:0]  power_mode_o;
    logic signed [IN_W-1:0] ain_i = 0;
    int          err_count = 0, check_count = 0, cyc = 0, n, ones;
    int          dv[3] = '{0, FS_CODE, -FS_CODE};
    int          dp[3] = '{50, 86, 14};
    sdml_if link ();
    sdml_modulator #(.LOSS_COUNT(LOSS)) sdml_modulator_inst (.mclk_i(mclk_i),
        .reset_n_i(reset_n_i), .link(link.modulator), .ain_i(ain_i), .chan_sel_i(chan_sel_i),
        .fourth_order_o(fourth_order_o), .power_mode_o(power_mode_o));
    sdml_filter sdml_filter_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .link(link.filter),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sys_sync_i(sys_sync_i),
        .sine_align_o(sine_align_o), .word_count_o(word_count_o));
    sdml_link_sva #(.LOSS_COUNT(LOSS)) sdml_link_sva_inst (.mclk_i(mclk_i),
        .reset_n_i(reset_n_i), .mod_clk(link.mod_clk), .samp_sync(link.samp_sync),
        .bit_data(link.bit_data), .bit_data_oe(link.bit_data_oe),
        .instability_flag(link.instability_flag),
        .instability_flag_oe(link.instability_flag_oe), .power_down_pin(link.power_down_pin));
    initial forever #5 mclk_i = ~mclk_i;
    // hang guard, well above the expected run length
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            err_count++;
            $display("unexpected at %0t: timeout", $time);
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string w);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("unexpected at %0t: %s got %0h want %0h", $time, w, g, e);
        end
    endtask
    task automatic chk_rng(input int g, input int lo, input int hi, input string w);
        check_count++;
        if (g < lo || g > hi) begin
            err_count++;
            $display("unexpected at %0t: %s %0d outside %0d..%0d", $time, w, g, lo, hi);
        end
    endtask
    // one apb transfer, entered and left just after a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge mclk_i);
        penable <= 1;
        do @(posedge mclk_i); while (pready !== 1'b1);
        rd = prdata;
        rerr = pslverr;
        psel <= 0; penable <= 0;
        @(posedge mclk_i);
    endtask
    // system sync pulse, noting what reaches the link meanwhile
    task automatic sync_pulse();
        s_sync = 0; s_align = 0; s_clk = 0;
        sys_sync_i <= 1;
        repeat (150) begin
            @(posedge mclk_i);
            s_sync |= link.samp_sync; s_align |= sine_align_o; s_clk |= link.mod_clk;
        end
        sys_sync_i <= 0;
        @(posedge mclk_i);
    endtask
    // ones over 200 clock rises, i.e. 50 output bits
    task automatic density(input logic signed [IN_W-1:0] v);
        ain_i <= v; ones = 0;
        repeat (400) @(posedge mclk_i);
        repeat (200) begin
            @(posedge link.mod_clk);
            ones += (link.bit_data === 1'b1);
        end
        @(posedge mclk_i);
    endtask
    task automatic wait_flag(input logic v);
        for (n = 0; n < 4000 && link.instability_flag !== v; n++) @(posedge mclk_i);
    endtask
    // main sequence
    initial begin
        repeat (16) @(posedge mclk_i);
        reset_n_i <= 1;
        @(posedge mclk_i);
        apb(0, CFG_OFS, 0); chk(rd, CFG_RST, "cfg reset");
        apb(0, 8'h10, 0); chk(rerr, 1, "unmapped");
        sync_pulse(); chk(s_sync, 0, "sync off");
        chk(s_clk, 0, "clock off");
        apb(1, CFG_OFS, 3);
        for (n = 0; n < 3000 && link.bit_data_oe !== 1'b1; n++) @(posedge mclk_i);
        chk(power_mode_o, SDML_RUN, "run mode");
        sync_pulse(); chk(s_sync, 1, "sync on");
        chk(s_align, 0, "no align");
        apb(1, SINE_OFS, 1); sync_pulse(); chk(s_align, 1, "align");
        $display("test setup ended");
        foreach (dv[i]) begin
            density(IN_W'(dv[i])); chk_rng(ones / 2, dp[i] - 8, dp[i] + 8, "density");
        end
        $display("test density ended");
        apb(1, PIN_OFS, 1); chan_sel_i <= 1;
        chk(link.idle_tone_offset_enable, 1, "offset pin");
        apb(0, PIN_OFS, 0); chk(rd, 1, "pin readback");
        ain_i <= OVR_CODE + 1000; wait_flag(1);
        chk(fourth_order_o, 0, "first order");
        apb(0, STAT_OFS, 0); chk(rd[ST_ERR_BIT], 1, "error bit");
        ain_i <= 0; wait_flag(0);
        chk_rng(n, 31 * 2 * MOD_HALF_CYC, 3999, "recovery");
        chk(fourth_order_o, 1, "fourth order");
        ain_i <= -OVR_CODE - 1000; ones = 0; s_clk = 0;
        repeat (12000) begin
            @(posedge mclk_i);
            ones += (link.instability_flag === 1'b1 && s_clk !== 1'b1);
            s_clk = link.instability_flag;
        end
        chk_rng(ones, 2, 1000, "flag pulses");
        ain_i <= 0; wait_flag(0);
        rd = word_count_o;
        for (n = 0; n < 13000 && word_count_o === rd; n++) @(posedge mclk_i);
        chk_rng(n, 1, 12999, "word end");
        apb(0, STAT_OFS, 0); chk(rd[ST_ERR_BIT], 0, "error cleared");
        $display("test stability ended");
        apb(1, PIN_OFS, 3); repeat (4) @(posedge mclk_i);
        chk(link.bit_data_oe, 0, "pd oe");
        chk(power_mode_o, SDML_PD_PIN, "pd mode");
        apb(1, PIN_OFS, 1);
        for (n = 0; n < 3000 && link.bit_data_oe !== 1'b1; n++) @(posedge mclk_i);
        apb(1, CFG_OFS, 0); repeat (LOSS / 2) @(posedge mclk_i);
        chk(power_mode_o, SDML_RUN, "not yet lost");
        repeat (LOSS) @(posedge mclk_i);
        chk(power_mode_o, SDML_PD_LOSS, "lost mode");
        chk(link.instability_flag_oe, 0, "lost oe");
        $display("test power ended");
        test_done();
    end
endmodule
`default_nettype wire
